// [pkg/rmseq_pkg.sv]
// rmseq_pkg: constants and types for the rail monitor sequencer
package rmseq_pkg;

  // ****************************************************************
  // clock, widths and counts
  // ****************************************************************
  localparam int CLK_MHZ   = 125;
  localparam int RES_W     = 16;
  localparam int NUM_SLOTS = 6;
  localparam int NUM_CH    = 3;
  localparam int TMR_W     = 24;
  localparam int AVS_AW    = 8;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RES0   = 8'h08;
  localparam logic [7:0] OFS_RESN   = 8'h20;
  localparam logic [7:0] OFS_PV_UP  = 8'h20;
  localparam logic [7:0] OFS_PV_LO  = 8'h24;

  // ****************************************************************
  // configuration fields
  // ****************************************************************
  localparam int CFG_RST_BIT   = 15;
  localparam int CFG_CHEN_MSB  = 14;
  localparam int CFG_AVG_LSB   = 9;
  localparam int CFG_BCT_LSB   = 6;
  localparam int CFG_SCT_LSB   = 3;
  localparam int MODE_SHUNT    = 0;
  localparam int MODE_BUS      = 1;
  localparam int MODE_CONT     = 2;
  localparam logic [2:0] CHEN_DEF = 3'h7;
  localparam logic [2:0] AVG_DEF  = 3'h0;
  localparam logic [2:0] CT_DEF   = 3'h4;
  localparam logic [2:0] MODE_DEF = 3'h7;
  localparam logic [15:0] CFG_DEFAULT =
    {1'b0, CHEN_DEF, AVG_DEF, CT_DEF, CT_DEF, MODE_DEF};

  // ****************************************************************
  // status fields
  // ****************************************************************
  localparam int ST_TC_BIT   = 0;
  localparam int ST_RG_BIT   = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_CHK_BIT  = 3;
  localparam int ST_SLOT_LSB = 4;

  // ****************************************************************
  // conversion time per code (us) and averaging shift per code
  // ****************************************************************
  localparam int CT_US [8] = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
  localparam int AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};

  // ****************************************************************
  // rail thresholds in result codes and timing check result count
  // ****************************************************************
  localparam logic [15:0] TC_THRESH = 16'h0096;
  localparam logic [2:0]  TC_CYCLES = 3'h4;
  localparam logic [15:0] PV_UP_DEF = 16'h04e2;
  localparam logic [15:0] PV_LO_DEF = 16'h0465;

  typedef enum logic {SQ_IDLE, SQ_CONV} rmseq_sq_t;
  typedef enum logic [2:0] {
    TC_CH1, TC_CH2, TC_PASS, TC_ALERT, TC_OFF
  } rmseq_tc_t;

endpackage

// [logic/rmseq_avg_store.sv]
// rmseq_avg_store: running-average output value per measured signal
module rmseq_avg_store
  import rmseq_pkg::*;
#(
  parameter int W = RES_W,
  parameter int N = NUM_SLOTS
) (
  input  wire logic                clk_sys_in,
  input  wire logic                clr_b_in,
  input  wire logic                ce_in,
  input  wire logic                upd_in,
  input  wire logic [2:0]          slot_in,
  input  wire logic [W-1:0]        sample_in,
  input  wire logic [3:0]          shift_in,
  output logic [N-1:0][W-1:0]      avg_out
);

  // ****************************************************************
  // one filter slot per signal
  // ****************************************************************
  for (genvar i = 0; i < N; i++) begin : g_slot
    logic [W-1:0]        avg_r;
    logic [W-1:0]        avg_nxt;
    logic signed [W:0]   diff;
    logic signed [W:0]   quot;
    logic signed [W:0]   sum;

    always_comb begin
      diff    = $signed({sample_in[W-1], sample_in})
              - $signed({avg_r[W-1], avg_r});
      quot    = diff >>> shift_in;
      sum     = $signed({avg_r[W-1], avg_r}) + quot;
      avg_nxt = avg_r;
      if (upd_in && slot_in == 3'(i)) begin
        avg_nxt = sum[W-1:0];
      end
    end

    always_ff @(posedge clk_sys_in) begin
      if (!clr_b_in) begin
        avg_r <= '0;
      end else if (ce_in) begin
        avg_r <= avg_nxt;
      end
    end

    assign avg_out[i] = avg_r;
  end

endmodule // rmseq_avg_store

// [logic/rmseq_top.sv]
// rmseq_top: measurement sequencer, averaging, rail checks, registers
module rmseq_top
  import rmseq_pkg::*;
#(
  parameter int CYC_PER_US = CLK_MHZ
) (
  input  wire logic               clk_sys_in,
  input  wire logic               rst_b_in,
  input  wire logic               ce_in,
  input  wire logic [AVS_AW-1:0]  avs_address_in,
  input  wire logic               avs_read_in,
  input  wire logic               avs_write_in,
  input  wire logic [31:0]        avs_writedata_in,
  input  wire logic [3:0]         avs_byteenable_in,
  output logic [31:0]             avs_readdata_out,
  output logic                    avs_waitrequest_out,
  input  wire logic [RES_W-1:0]   adc_data_in,
  output logic                    adc_start_out,
  output logic [1:0]              adc_chan_out,
  output logic                    adc_bus_sel_out,
  output logic                    raw_valid_out,
  output logic [RES_W-1:0]        raw_data_out,
  output logic [2:0]              raw_slot_out,
  output logic                    timing_sequence_alert_n_out,
  output logic                    rail_good_output_out
);

  // ****************************************************************
  // helper functions
  // ****************************************************************
  function automatic logic slot_en(input logic [2:0] s,
                                   input logic [15:0] cfg);
    logic [1:0] ch;
    ch = s[2:1];
    return cfg[CFG_CHEN_MSB - int'(ch)]
         & cfg[s[0] ? MODE_BUS : MODE_SHUNT];
  endfunction

  // search forward from cur; wrap flags a return to the same or an earlier slot
  function automatic logic [4:0] next_slot(input logic [2:0] cur,
                                           input logic [15:0] cfg);
    logic [4:0] res;
    logic [2:0] cand;
    res = '0;
    for (int k = 1; k <= NUM_SLOTS; k++) begin
      cand = 3'((int'(cur) + k) % NUM_SLOTS);
      if (!res[4] && slot_en(cand, cfg)) begin
        res = {1'b1, cand <= cur, cand};
      end
    end
    return res;
  endfunction

  function automatic logic [TMR_W-1:0] conv_cycles(
      input logic [2:0] s, input logic [15:0] cfg);
    logic [2:0] code;
    code = s[0] ? cfg[CFG_BCT_LSB +: 3] : cfg[CFG_SCT_LSB +: 3];
    return TMR_W'(CT_US[code] * CYC_PER_US);
  endfunction

  function automatic logic [15:0] be_merge(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [15:0] o;
    o = old;
    for (int b = 0; b < 2; b++) begin
      if (be[b]) begin
        o[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return o;
  endfunction

  // ****************************************************************
  // bus slave: one wait cycle on every access
  // ****************************************************************
  logic               ack_r;
  logic               ack_nxt;
  logic [31:0]        rdata_r;
  logic [31:0]        rdata_nxt;
  logic               wr_acc;
  logic               cfg_wr;
  logic               soft_rst;
  logic               cfg_chg;
  logic               clr_b;
  logic [15:0]        cfg_merged;
  logic [NUM_SLOTS-1:0][RES_W-1:0] avg_val;

  // ****************************************************************
  // register and status state
  // ****************************************************************
  logic [15:0]        cfg_r;
  logic [15:0]        cfg_nxt;
  logic [15:0]        pv_up_r;
  logic [15:0]        pv_up_nxt;
  logic [15:0]        pv_lo_r;
  logic [15:0]        pv_lo_nxt;

  // ****************************************************************
  // sequencer, check and rail state
  // ****************************************************************
  rmseq_sq_t          sq_r;
  rmseq_sq_t          sq_nxt;
  logic [2:0]         slot_r;
  logic [2:0]         slot_nxt;
  logic [TMR_W-1:0]   tmr_r;
  logic [TMR_W-1:0]   tmr_nxt;
  logic               kick_r;
  logic               kick_nxt;
  logic               start_r;
  logic               start_nxt;
  logic               rv_r;
  logic               rv_nxt;
  logic [RES_W-1:0]   raw_r;
  logic [RES_W-1:0]   raw_nxt;
  logic [2:0]         rslot_r;
  logic [2:0]         rslot_nxt;
  logic               aupd_r;
  logic [2:0]         aslot_r;
  logic [4:0]         nx;
  rmseq_tc_t          tc_r;
  rmseq_tc_t          tc_nxt;
  logic [2:0]         tcc_r;
  logic [2:0]         tcc_nxt;
  logic [NUM_CH-1:0]  seen_r;
  logic [NUM_CH-1:0]  seen_nxt;
  logic [NUM_CH-1:0]  hi_r;
  logic [NUM_CH-1:0]  hi_nxt;
  logic [NUM_CH-1:0]  lo_r;
  logic [NUM_CH-1:0]  lo_nxt;
  logic               rg_r;
  logic               rg_nxt;

  assign wr_acc     = avs_write_in & ack_r;
  assign cfg_wr     = wr_acc & (avs_address_in == OFS_CONFIG);
  assign cfg_merged = be_merge(cfg_r, avs_writedata_in, avs_byteenable_in);
  assign soft_rst   = cfg_wr & cfg_merged[CFG_RST_BIT];
  assign cfg_chg    = cfg_wr & ~cfg_merged[CFG_RST_BIT];
  // soft reset clears all but rail good and the bus slave on the same clear as power-up
  assign clr_b      = rst_b_in & ~(soft_rst & ce_in);

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
  assign avs_readdata_out    = rdata_r;

  always_comb begin
    ack_nxt   = (avs_read_in | avs_write_in) & ~ack_r;
    rdata_nxt = rdata_r;
    if (avs_read_in && !ack_r) begin
      rdata_nxt = '0;
      if (avs_address_in == OFS_CONFIG) begin
        rdata_nxt[15:0] = cfg_r;
      end else if (avs_address_in == OFS_STATUS) begin
        rdata_nxt[ST_TC_BIT]   = ~timing_sequence_alert_n_out;
        rdata_nxt[ST_RG_BIT]   = rg_r;
        rdata_nxt[ST_BUSY_BIT] = (sq_r == SQ_CONV);
        rdata_nxt[ST_CHK_BIT]  = (tc_r == TC_CH1) || (tc_r == TC_CH2);
        rdata_nxt[ST_SLOT_LSB +: 3] = slot_r;
      end else if (avs_address_in == OFS_PV_UP) begin
        rdata_nxt[15:0] = pv_up_r;
      end else if (avs_address_in == OFS_PV_LO) begin
        rdata_nxt[15:0] = pv_lo_r;
      end else if (avs_address_in >= OFS_RES0 &&
                   avs_address_in < OFS_RESN &&
                   avs_address_in[1:0] == 2'h0) begin
        rdata_nxt[15:0] = avg_val[3'((avs_address_in - OFS_RES0) >> 2)];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      ack_r   <= 1'b0;
      rdata_r <= '0;
    end else if (ce_in) begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // writable registers
  // ****************************************************************
  always_comb begin
    cfg_nxt   = cfg_chg ? {1'b0, cfg_merged[14:0]} : cfg_r;
    pv_up_nxt = pv_up_r;
    pv_lo_nxt = pv_lo_r;
    if (wr_acc && avs_address_in == OFS_PV_UP) begin
      pv_up_nxt = be_merge(pv_up_r, avs_writedata_in, avs_byteenable_in);
    end
    if (wr_acc && avs_address_in == OFS_PV_LO) begin
      pv_lo_nxt = be_merge(pv_lo_r, avs_writedata_in, avs_byteenable_in);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!clr_b) begin
      cfg_r   <= CFG_DEFAULT;
      pv_up_r <= PV_UP_DEF;
      pv_lo_r <= PV_LO_DEF;
    end else if (ce_in) begin
      cfg_r   <= cfg_nxt;
      pv_up_r <= pv_up_nxt;
      pv_lo_r <= pv_lo_nxt;
    end
  end

  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  // a config write aborts the running conversion and restarts at the first enabled slot
  always_comb begin
    sq_nxt    = sq_r;
    slot_nxt  = slot_r;
    tmr_nxt   = tmr_r;
    kick_nxt  = kick_r | cfg_chg;
    start_nxt = 1'b0;
    rv_nxt    = 1'b0;
    raw_nxt   = raw_r;
    rslot_nxt = rslot_r;
    nx        = next_slot(3'(NUM_SLOTS - 1), cfg_r);
    if (kick_r) begin
      kick_nxt = cfg_chg;
      sq_nxt   = SQ_IDLE;
      if (nx[4]) begin
        sq_nxt    = SQ_CONV;
        slot_nxt  = nx[2:0];
        tmr_nxt   = conv_cycles(nx[2:0], cfg_r);
        start_nxt = 1'b1;
      end
    end else if (sq_r == SQ_CONV) begin
      if (tmr_r == TMR_W'(1)) begin
        raw_nxt   = adc_data_in;
        rv_nxt    = 1'b1;
        rslot_nxt = slot_r;
        nx        = next_slot(slot_r, cfg_r);
        if (!nx[4] || (nx[3] && !cfg_r[MODE_CONT])) begin
          sq_nxt = SQ_IDLE;
        end else begin
          slot_nxt  = nx[2:0];
          tmr_nxt   = conv_cycles(nx[2:0], cfg_r);
          start_nxt = 1'b1;
        end
      end else begin
        tmr_nxt = tmr_r - TMR_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!clr_b) begin
      sq_r    <= SQ_IDLE;
      slot_r  <= '0;
      tmr_r   <= '0;
      kick_r  <= 1'b1;
      start_r <= 1'b0;
      rv_r    <= 1'b0;
      raw_r   <= '0;
      rslot_r <= '0;
      aupd_r  <= 1'b0;
      aslot_r <= '0;
    end else if (ce_in) begin
      sq_r    <= sq_nxt;
      slot_r  <= slot_nxt;
      tmr_r   <= tmr_nxt;
      kick_r  <= kick_nxt;
      start_r <= start_nxt;
      rv_r    <= rv_nxt;
      raw_r   <= raw_nxt;
      rslot_r <= rslot_nxt;
      aupd_r  <= rv_r;
      aslot_r <= rslot_r;
    end
  end

  assign adc_start_out   = start_r;
  assign adc_chan_out    = slot_r[2:1];
  assign adc_bus_sel_out = slot_r[0];
  assign raw_valid_out   = rv_r;
  assign raw_data_out    = raw_r;
  assign raw_slot_out    = rslot_r;

  rmseq_avg_store #(
    .W (RES_W),
    .N (NUM_SLOTS)
  ) rmseq_avg_store_inst (
    .clk_sys_in (clk_sys_in),
    .clr_b_in   (clr_b),
    .ce_in      (ce_in),
    .upd_in     (rv_r),
    .slot_in    (rslot_r),
    .sample_in  (raw_r),
    .shift_in   (4'(AVG_SHIFT[cfg_r[CFG_AVG_LSB +: 3]])),
    .avg_out    (avg_val)
  );

  // ****************************************************************
  // timing sequence check
  // ****************************************************************
  always_comb begin
    tc_nxt  = tc_r;
    tcc_nxt = tcc_r;
    if (cfg_chg && (tc_r == TC_CH1 || tc_r == TC_CH2)) begin
      tc_nxt = TC_OFF;
    end else if (rv_r && rslot_r == 3'h1 && tc_r == TC_CH1) begin
      if (raw_r >= TC_THRESH) begin
        tc_nxt  = TC_CH2;
        tcc_nxt = '0;
      end
    end else if (rv_r && tc_r == TC_CH2) begin
      if (rslot_r == 3'h3 && raw_r >= TC_THRESH) begin
        tc_nxt = TC_PASS;
      end else if (rslot_r == 3'h1) begin
        tcc_nxt = tcc_r + 3'h1;
        if (tcc_r + 3'h1 == TC_CYCLES) begin
          tc_nxt = TC_ALERT;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!clr_b) begin
      tc_r  <= TC_CH1;
      tcc_r <= '0;
    end else if (ce_in) begin
      tc_r  <= tc_nxt;
      tcc_r <= tcc_nxt;
    end
  end

  assign timing_sequence_alert_n_out = (tc_r != TC_ALERT);

  // ****************************************************************
  // rail good detection on averaged bus values
  // ****************************************************************
  always_comb begin
    seen_nxt = seen_r;
    hi_nxt   = hi_r;
    lo_nxt   = lo_r;
    rg_nxt   = rg_r;
    if (aupd_r && aslot_r[0]) begin
      seen_nxt[aslot_r[2:1]] = 1'b1;
      hi_nxt[aslot_r[2:1]]   = avg_val[aslot_r] >= pv_up_r;
      lo_nxt[aslot_r[2:1]]   = avg_val[aslot_r] < pv_lo_r;
    end
    // the soft reset edge itself must not let rail good drop
    if (&seen_r && clr_b) begin
      if (!rg_r && &hi_r) begin
        rg_nxt = 1'b1;
      end else if (rg_r && |lo_r) begin
        rg_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!clr_b) begin
      seen_r <= '0;
      hi_r   <= '0;
      lo_r   <= '0;
    end else if (ce_in) begin
      seen_r <= seen_nxt;
      hi_r   <= hi_nxt;
      lo_r   <= lo_nxt;
    end
  end

  // only power-up clears rail good; soft reset leaves it standing
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      rg_r <= 1'b0;
    end else if (ce_in) begin
      rg_r <= rg_nxt;
    end
  end

  assign rail_good_output_out = rg_r;

endmodule // rmseq_top

// [test/rmseq_checker.sv]
// rmseq_checker: bus, sequencer and rail check properties of rmseq_top
module rmseq_checker
  import rmseq_pkg::*;
(
  input wire logic              clk_sys_in,
  input wire logic              rst_b_in,
  input wire logic [AVS_AW-1:0] avs_address_in,
  input wire logic              avs_read_in,
  input wire logic              avs_write_in,
  input wire logic [31:0]       avs_writedata_in,
  input wire logic [3:0]        avs_byteenable_in,
  input wire logic              avs_waitrequest_out,
  input wire logic              adc_start_out,
  input wire logic [1:0]        adc_chan_out,
  input wire logic              adc_bus_sel_out,
  input wire logic              raw_valid_out,
  input wire logic [RES_W-1:0]  raw_data_out,
  input wire logic [2:0]        raw_slot_out,
  input wire logic              timing_sequence_alert_n_out,
  input wire logic              rail_good_output_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  logic req;
  logic sr_ack;
  assign req = avs_read_in | avs_write_in;
  assign sr_ack = avs_write_in & ~avs_waitrequest_out
                & avs_writedata_in[CFG_RST_BIT] & avs_byteenable_in[1]
                & (avs_address_in == OFS_CONFIG);

  sequence s_pend;
    req && avs_waitrequest_out;
  endsequence
  sequence s_ack;
    req && !avs_waitrequest_out;
  endsequence

  a_bus_ack_one: assert property (s_pend |=> !avs_waitrequest_out)
    else $error("no bus answer one cycle after request");
  a_ack_single: assert property (s_ack ##1 req |-> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_first_start: assert property ($rose(rst_b_in) |=> adc_start_out
    && adc_chan_out == 2'h0 && !adc_bus_sel_out)
    else $error("first conversion not channel one shunt");
  a_reset_outs: assert property ($rose(rst_b_in) |->
    timing_sequence_alert_n_out && !rail_good_output_out)
    else $error("outputs not at reset level");
  // a config write may abort and restart at once, so it is excluded
  a_start_pulse: assert property (adc_start_out && !avs_write_in
    |=> !adc_start_out)
    else $error("start pulse longer than one cycle");
  a_raw_source: assert property (raw_valid_out |-> raw_slot_out ==
    {$past(adc_chan_out), $past(adc_bus_sel_out)})
    else $error("raw slot differs from converted slot");
  a_raw_hold: assert property (!raw_valid_out && !$past(sr_ack)
    |-> $stable(raw_data_out))
    else $error("raw result changed without valid");
  a_alert_cause: assert property ($fell(timing_sequence_alert_n_out)
    |-> raw_slot_out == 3'h1)
    else $error("alert fell outside channel one bus result");
  a_alert_sticky: assert property (!timing_sequence_alert_n_out
    && !sr_ack |=> !timing_sequence_alert_n_out)
    else $error("alert released without soft reset");
  a_alert_soft: assert property (sr_ack |=> timing_sequence_alert_n_out)
    else $error("alert not cleared by soft reset");
  a_rail_rise: assert property ($rose(rail_good_output_out)
    |-> raw_slot_out[0])
    else $error("rail good rose outside a bus result");
  a_rail_hold: assert property (sr_ack && rail_good_output_out
    |=> rail_good_output_out)
    else $error("rail good dropped by soft reset");
endmodule // rmseq_checker

bind rmseq_top rmseq_checker rmseq_checker_inst (
  .clk_sys_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out,
  .adc_start_out, .adc_chan_out, .adc_bus_sel_out, .raw_valid_out,
  .raw_data_out, .raw_slot_out, .timing_sequence_alert_n_out,
  .rail_good_output_out
);

// [test/test_rail_monitor_sequencer.sv]
// test_rail_monitor_sequencer: self-checking bench for rmseq_top
module test_rail_monitor_sequencer
  import rmseq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // signals and design
  // ****************************************************************
  logic              clk_sys_in = 1'b0;
  logic              rst_b_in = 1'b0;
  logic [AVS_AW-1:0] avs_address_in = '0;
  logic              avs_read_in = 1'b0;
  logic              avs_write_in = 1'b0;
  logic [31:0]       avs_writedata_in = '0;
  logic [3:0]        avs_byteenable_in = 4'h3;
  logic [31:0]       avs_readdata_out;
  logic              avs_waitrequest_out;
  logic [RES_W-1:0]  adc_data_in = '0;
  logic              adc_start_out;
  logic [1:0]        adc_chan_out;
  logic              adc_bus_sel_out;
  logic              raw_valid_out;
  logic [RES_W-1:0]  raw_data_out;
  logic [2:0]        raw_slot_out;
  logic              timing_sequence_alert_n_out;
  logic              rail_good_output_out;
  logic [15:0]       sv [6] = '{16'h0010, 16'h0500, 16'h0020,
                                16'h0000, 16'h0030, 16'h0500};
  int                err_total = 0;
  int                cmp_count = 0;

  rmseq_top #(.CYC_PER_US(1)) rmseq_top_inst (
    .clk_sys_in, .rst_b_in, .ce_in(1'b1), .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .adc_data_in, .adc_start_out, .adc_chan_out,
    .adc_bus_sel_out, .raw_valid_out, .raw_data_out, .raw_slot_out,
    .timing_sequence_alert_n_out, .rail_good_output_out
  );

  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // converter stand-in: each slot returns its own level from sv, which the tests change
  always @(posedge clk_sys_in) begin
    adc_data_in <= sv[{adc_chan_out, adc_bus_sel_out}];
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic summarize();
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    avs_address_in <= a;
    avs_writedata_in <= {16'h0000, d};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out[15:0];
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input string nm);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    cmp(nm, e, q);
  endtask

  // counts edges up to and including the next raw result
  task automatic next_raw(output int g);
    g = 0;
    do begin
      @(posedge clk_sys_in);
      g++;
    end while (raw_valid_out !== 1'b1);
  endtask

  task automatic t_reset();
    repeat (2) @(posedge clk_sys_in);
    cmp("start", 1'b1, adc_start_out);
    cmp("slot", 3'h0, {adc_chan_out, adc_bus_sel_out});
    rd(OFS_CONFIG, CFG_DEFAULT, "config");
    rd(OFS_PV_LO, PV_LO_DEF, "lo_lim");
    rd(8'h40, 16'h0000, "unmapped");
  endtask

  task automatic t_alert();
    int g;
    int n;
    n = 0;
    for (int i = 0; i < 32; i++) begin
      next_raw(g);
      cmp("slot", i % 6, raw_slot_out);
      cmp("raw", sv[raw_slot_out], raw_data_out);
      if (i > 0)
        cmp("gap", CT_US[CT_DEF], g);
      if (raw_slot_out == 3'h1)
        n++;
      // the fifth channel one result is the one that may trip the alert
      if (!(raw_slot_out == 3'h1 && n == 5))
        cmp("alert", n < 5, timing_sequence_alert_n_out);
    end
    cmp("rail", 1'b0, rail_good_output_out);
  endtask

  task automatic t_soft();
    int g;
    logic [15:0] q;
    sv[3] = 16'h0500;
    bus(1'b1, OFS_PV_UP, 16'h0600, q);
    bus(1'b1, OFS_CONFIG, 16'h8000, q);
    cmp("alert", 1'b1, timing_sequence_alert_n_out);
    rd(OFS_CONFIG, CFG_DEFAULT, "config");
    rd(OFS_PV_UP, PV_UP_DEF, "up_lim");
    repeat (7) next_raw(g);
    repeat (3) @(posedge clk_sys_in);
    cmp("rail", 1'b1, rail_good_output_out);
    bus(1'b1, OFS_CONFIG, 16'h8000, q);
    cmp("rail", 1'b1, rail_good_output_out);
    sv[3] = 16'h0000;
  endtask

  task automatic t_seq(input logic [15:0] cfg, input logic [23:0] pat,
                       input int len, input int n);
    int g;
    logic [15:0] q;
    bus(1'b1, OFS_CONFIG, cfg, q);
    for (int i = 0; i < n; i++) begin
      next_raw(g);
      cmp("slot", pat[4*(i%len) +: 3], raw_slot_out);
      cmp("restart", 1'b1, adc_start_out);
      if (i > 0)
        cmp("gap", CT_US[raw_slot_out[0] ? cfg[8:6] : cfg[5:3]], g);
    end
  endtask

  task automatic t_avg();
    int g;
    logic [15:0] q;
    bus(1'b0, OFS_STATUS, 16'h0000, q);
    cmp("checking", 1'b0, q[ST_CHK_BIT]);
    rd(OFS_RES0, 16'h0010, "avg0");
    bus(1'b1, OFS_CONFIG, 16'h4205, q);
    sv[0] = 16'h0210;
    next_raw(g);
    repeat (2) @(posedge clk_sys_in);
    rd(OFS_RES0, 16'h0090, "avg1");
    next_raw(g);
    repeat (2) @(posedge clk_sys_in);
    rd(OFS_RES0, 16'h00f0, "avg2");
  endtask

  // single shot: one pass over the enabled slots, then idle
  task automatic t_single();
    int g;
    logic [15:0] q;
    bus(1'b1, OFS_CONFIG, 16'h4001, q);
    next_raw(g);
    cmp("slot", 3'h0, raw_slot_out);
    cmp("restart", 1'b0, adc_start_out);
    bus(1'b0, OFS_STATUS, 16'h0000, q);
    cmp("busy", 1'b0, q[ST_BUSY_BIT]);
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (80000) @(posedge clk_sys_in);
    err_total++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_alert();
    t_soft();
    t_seq(16'h4005, 24'h000000, 1, 3);
    t_avg();
    t_seq(16'h7005, 24'h000420, 3, 6);
    t_seq(16'h6006, 24'h000031, 2, 4);
    t_seq(16'h7047, 24'h543210, 6, 30);
    t_single();
    cmp("alert", 1'b1, timing_sequence_alert_n_out);
    summarize();
  end
endmodule // test_rail_monitor_sequencer
